// ---- rtl/pirf_top.sv ----
// Peripheral interrupt request flags for the serial units and timers, with an Avalon-MM slave.
//
// Contract
// - Receive-pending flag is high while the receive buffer holds a byte.
// - Receive-pending flag is read-only; it clears when software drains the buffer.
// - Transmit-space flag is high while the transmit buffer has a free slot.
// - Transmit-space flag is read-only; it clears when software fills the buffer.
// - Transmit-space flag never reports transmit completion; the shifter-empty bit does.
// - Bus collision latches its flag until software writes it to zero.
// - Synchronous-port completion latches its flag until software clears it.
// - Postscaler overflow, or period match at postscale 1:1, latches the period flag.
// - Counter overflow latches its flag until software writes it to zero.
// - Flags are set by events regardless of any interrupt enable.
// - Unused flag bits ignore writes and read as zero.
// - Latched flags reset to zero on every reset; receive-pending and transmit-space follow their inputs.
`timescale 1ns/100ps
module pirf_top #(
   parameter int unsigned ADDR_W = 5
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_buf_not_empty,
   input wire logic tx_buf_not_full,
   input wire logic tx_shifter_empty,
   input wire logic sync_collision_evt,
   input wire logic sync_done_evt,
   input wire logic period_match_evt,
   input wire logic postscale_ovf_evt,
   input wire logic postscale_is_1to1,
   input wire logic counter_ovf_evt,
   output logic irq
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [pirf_pkg::IRQ_W-1:0] status;
      logic [pirf_pkg::IRQ_W-1:0] mask;
      logic rx_prev;
      logic tx_prev;
   } pirf_top_state_t;

   pirf_top_state_t s_q;
   pirf_top_state_t s_d;

   pirf_latch_if #(.W(pirf_pkg::LATCH_W)) lb ();

   pirf_latch_bank #(.W(pirf_pkg::LATCH_W)) u_bank (
      .clock(clock),
      .rst_n(rst_n),
      .lb(lb)
   );

   initial begin
      if (ADDR_W < pirf_pkg::ADDR_W_MIN) begin
         $error("pirf_top needs an address of at least five bits");
      end
   end

   // Word decode: the upper address bits must be zero and the byte offset bits are ignored.
   function automatic logic reg_sel(input logic [ADDR_W-1:0] addr, input logic [4:0] ofs);
      logic [ADDR_W-1:0] wide;
      wide = ADDR_W'(ofs);
      reg_sel = (addr[ADDR_W-1:2] == wide[ADDR_W-1:2]);
   endfunction : reg_sel

   logic req;
   logic write_fire;
   logic [7:0] serial_view;
   logic [7:0] timer_view;
   logic [pirf_pkg::IRQ_W-1:0] evt;
   logic period_set;

   always_comb begin
      // The transmit-space flag follows only buffer room, never the shifter.
      serial_view = pirf_pkg::FLAGS_RESET;
      serial_view[pirf_pkg::SER_RX_PENDING] = rx_buf_not_empty;
      serial_view[pirf_pkg::SER_TX_SPACE] = tx_buf_not_full;
      serial_view[pirf_pkg::SER_BUS_COLL] = lb.flags[pirf_pkg::LB_BUS_COLL];
      serial_view[pirf_pkg::SER_PORT_EVT] = lb.flags[pirf_pkg::LB_PORT_EVT];
      timer_view = pirf_pkg::FLAGS_RESET;
      timer_view[pirf_pkg::TMR_PERIOD] = lb.flags[pirf_pkg::LB_PERIOD];
      timer_view[pirf_pkg::TMR_COUNTER] = lb.flags[pirf_pkg::LB_COUNTER];
   end

   // The period flag sets on postscaler overflow, or on a bare match when postscaling is 1:1.
   assign period_set = postscale_ovf_evt | (postscale_is_1to1 & period_match_evt);

   // Hardware sets reach the bank without regard to any mask or enable.
   always_comb begin
      lb.set = '0;
      lb.set[pirf_pkg::LB_PORT_EVT] = sync_done_evt;
      lb.set[pirf_pkg::LB_BUS_COLL] = sync_collision_evt;
      lb.set[pirf_pkg::LB_COUNTER] = counter_ovf_evt;
      lb.set[pirf_pkg::LB_PERIOD] = period_set;
   end

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~s_q.ack;
   assign write_fire = avs_write & s_q.ack & avs_byteenable[0];

   // Writes reach only the latched bits; read-only and unused positions are dropped.
   always_comb begin
      lb.wr_en = '0;
      lb.wr_data = '0;
      if (write_fire && reg_sel(avs_address, pirf_pkg::OFS_SERIAL_FLAGS)) begin
         lb.wr_en[pirf_pkg::LB_BUS_COLL] = 1'b1;
         lb.wr_en[pirf_pkg::LB_PORT_EVT] = 1'b1;
         lb.wr_data[pirf_pkg::LB_BUS_COLL] = avs_writedata[pirf_pkg::SER_BUS_COLL];
         lb.wr_data[pirf_pkg::LB_PORT_EVT] = avs_writedata[pirf_pkg::SER_PORT_EVT];
      end
      if (write_fire && reg_sel(avs_address, pirf_pkg::OFS_TIMER_FLAGS)) begin
         lb.wr_en[pirf_pkg::LB_PERIOD] = 1'b1;
         lb.wr_en[pirf_pkg::LB_COUNTER] = 1'b1;
         lb.wr_data[pirf_pkg::LB_PERIOD] = avs_writedata[pirf_pkg::TMR_PERIOD];
         lb.wr_data[pirf_pkg::LB_COUNTER] = avs_writedata[pirf_pkg::TMR_COUNTER];
      end
   end

   always_comb begin
      evt = '0;
      evt[pirf_pkg::IRQ_PORT_EVT] = sync_done_evt;
      evt[pirf_pkg::IRQ_BUS_COLL] = sync_collision_evt;
      evt[pirf_pkg::IRQ_COUNTER] = counter_ovf_evt;
      evt[pirf_pkg::IRQ_PERIOD] = period_set;
      evt[pirf_pkg::IRQ_TX_SPACE] = tx_buf_not_full & ~s_q.tx_prev;
      evt[pirf_pkg::IRQ_RX_PENDING] = rx_buf_not_empty & ~s_q.rx_prev;
   end

   always_comb begin
      s_d = s_q;
      s_d.ack = req & ~s_q.ack;
      s_d.rx_prev = rx_buf_not_empty;
      s_d.tx_prev = tx_buf_not_full;
      if (avs_read && !s_q.ack) begin
         s_d.rdata = pirf_pkg::RDATA_RESET;
         if (reg_sel(avs_address, pirf_pkg::OFS_SERIAL_FLAGS)) begin
            s_d.rdata[7:0] = serial_view;
         end else if (reg_sel(avs_address, pirf_pkg::OFS_TIMER_FLAGS)) begin
            s_d.rdata[7:0] = timer_view;
         end else if (reg_sel(avs_address, pirf_pkg::OFS_IRQ_STATUS)) begin
            s_d.rdata[pirf_pkg::IRQ_W-1:0] = s_q.status;
         end else if (reg_sel(avs_address, pirf_pkg::OFS_IRQ_MASK)) begin
            s_d.rdata[pirf_pkg::IRQ_W-1:0] = s_q.mask;
         end else if (reg_sel(avs_address, pirf_pkg::OFS_TX_SHIFT)) begin
            s_d.rdata[0] = tx_shifter_empty;
         end
      end
      // Writing one clears a sticky bit, but a new event in that cycle wins.
      if (write_fire && reg_sel(avs_address, pirf_pkg::OFS_IRQ_STATUS)) begin
         s_d.status = s_q.status & ~avs_writedata[pirf_pkg::IRQ_W-1:0];
      end
      s_d.status = s_d.status | evt;
      if (write_fire && reg_sel(avs_address, pirf_pkg::OFS_IRQ_MASK)) begin
         s_d.mask = avs_writedata[pirf_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q.ack <= 1'b0;
         s_q.rdata <= pirf_pkg::RDATA_RESET;
         s_q.status <= pirf_pkg::IRQ_RESET;
         s_q.mask <= pirf_pkg::IRQ_RESET;
         s_q.rx_prev <= 1'b0;
         s_q.tx_prev <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata = s_q.rdata;
   assign irq = |(s_q.status & s_q.mask);
endmodule : pirf_top

// ---- rtl/pirf_pkg.sv ----
// Package with the register map, field positions and reset values of the peripheral flag block.
package pirf_pkg;
   localparam int unsigned ADDR_W_MIN = 5;
   localparam logic [4:0] OFS_SERIAL_FLAGS = 5'h00;
   localparam logic [4:0] OFS_TIMER_FLAGS = 5'h04;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h08;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h0C;
   localparam logic [4:0] OFS_TX_SHIFT = 5'h10;

   // Fields of serial_irq_flags.
   localparam int unsigned SER_RX_PENDING = 5;
   localparam int unsigned SER_TX_SPACE = 4;
   localparam int unsigned SER_BUS_COLL = 1;
   localparam int unsigned SER_PORT_EVT = 0;
   // Fields of timer_irq_flags.
   localparam int unsigned TMR_PERIOD = 1;
   localparam int unsigned TMR_COUNTER = 0;

   // Positions inside the latched flag bank.
   localparam int unsigned LATCH_W = 4;
   localparam int unsigned LB_PORT_EVT = 0;
   localparam int unsigned LB_BUS_COLL = 1;
   localparam int unsigned LB_COUNTER = 2;
   localparam int unsigned LB_PERIOD = 3;

   // Fields of the sticky status and mask registers.
   localparam int unsigned IRQ_W = 6;
   localparam int unsigned IRQ_PORT_EVT = 0;
   localparam int unsigned IRQ_BUS_COLL = 1;
   localparam int unsigned IRQ_COUNTER = 2;
   localparam int unsigned IRQ_PERIOD = 3;
   localparam int unsigned IRQ_TX_SPACE = 4;
   localparam int unsigned IRQ_RX_PENDING = 5;

   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage : pirf_pkg

// ---- rtl/pirf_latch_if.sv ----
// Interface between the top module and its bank of software-cleared flags.
`timescale 1ns/100ps
interface pirf_latch_if #(parameter int unsigned W = 4);
   logic [W-1:0] set;
   logic [W-1:0] wr_en;
   logic [W-1:0] wr_data;
   logic [W-1:0] flags;
   modport bank (input set, input wr_en, input wr_data, output flags);
   modport user (output set, output wr_en, output wr_data, input flags);
endinterface : pirf_latch_if

// ---- rtl/pirf_latch_bank.sv ----
// Bank of hardware-set flags that software may overwrite, with the hardware set winning.
`timescale 1ns/100ps
module pirf_latch_bank #(
   parameter int unsigned W = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   pirf_latch_if.bank lb
);
   typedef struct packed {
      logic [W-1:0] flags;
   } pirf_bank_state_t;

   pirf_bank_state_t s_q;
   pirf_bank_state_t s_d;

   initial begin
      if (W < 1) begin
         $error("pirf_latch_bank needs at least one flag");
      end
   end

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < int'(W); i++) begin
         // A set in the same cycle as a write of zero leaves the flag set.
         s_d.flags[i] = lb.set[i] | (lb.wr_en[i] ? lb.wr_data[i] : s_q.flags[i]);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q.flags <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lb.flags = s_q.flags;
endmodule : pirf_latch_bank

// ---- tb/pirf_sva.sv ----
// Port-level assertions for the peripheral flag block.
`timescale 1ns/100ps
module pirf_sva #(parameter int unsigned ADDR_W = 5) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic rx_buf_not_empty,
   input wire logic tx_buf_not_full,
   input wire logic sync_collision_evt,
   input wire logic sync_done_evt,
   input wire logic postscale_ovf_evt,
   input wire logic counter_ovf_evt,
   input wire logic irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic rd_s;
   logic rd_t;
   assign rd_s = avs_read & ~avs_waitrequest & (avs_address[4:2] == 3'h0);
   assign rd_t = avs_read & ~avs_waitrequest & (avs_address[4:2] == 3'h1);
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   a_one_wait_cycle: assert property ($rose(avs_read) |-> s_one_wait) else $error("read wait state wrong");
   a_rx_level_flag: assert property (rd_s && $past(rx_buf_not_empty) == $past(rx_buf_not_empty, 2)
      |-> avs_readdata[5] == $past(rx_buf_not_empty)) else $error("rx flag wrong");
   a_tx_level_flag: assert property (rd_s && $past(tx_buf_not_full) == $past(tx_buf_not_full, 2)
      |-> avs_readdata[4] == $past(tx_buf_not_full)) else $error("tx flag wrong");
   a_ser_unused_zero: assert property (rd_s |-> avs_readdata[31:6] == 26'h0 && avs_readdata[3:2] == 2'h0)
      else $error("serial unused bits set");
   a_tmr_unused_zero: assert property (rd_t |-> avs_readdata[31:2] == 30'h0) else $error("timer unused bits set");
   a_done_flag_set: assert property (rd_s && $past(sync_done_evt, 2) |-> avs_readdata[0]) else $error("done lost");
   a_coll_flag_set: assert property (rd_s && $past(sync_collision_evt, 2) |-> avs_readdata[1])
      else $error("collision lost");
   a_ovf_flag_set: assert property (rd_t && $past(postscale_ovf_evt, 2) |-> avs_readdata[1]) else $error("ovf lost");
   a_cnt_flag_set: assert property (rd_t && $past(counter_ovf_evt, 2) |-> avs_readdata[0]) else $error("cnt lost");
   a_reset_clears_out: assert property ($rose(rst_n) |-> avs_readdata == 32'h0 && !irq) else $error("reset value");
endmodule : pirf_sva
bind pirf_top pirf_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// ---- tb/pirf_tb_top.sv ----
// Self-checking testbench of the peripheral flag block.
`timescale 1ns/100ps
module pirf_tb_top;
   logic clock = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, irq;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, v;
   logic [3:0] avs_byteenable = 4'hF;
   logic rx_buf_not_empty = 1'h0, tx_buf_not_full = 1'h0, tx_shifter_empty = 1'h0, sync_collision_evt = 1'h0;
   logic sync_done_evt = 1'h0, period_match_evt = 1'h0, postscale_ovf_evt = 1'h0, postscale_is_1to1 = 1'h0;
   logic counter_ovf_evt = 1'h0;
   logic [31:0] exp_q[$], msk_q[$];
   int n_mismatch = 0, tests_run = 0;
   pirf_top #(.ADDR_W(5)) dut (.*);
   always #5 clock = ~clock;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   task automatic wait_ack;
      int i;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (avs_waitrequest !== 1'h0 && i < 20);
      if (avs_waitrequest !== 1'h0) begin
         n_mismatch++;
         end_sim();
      end
   endtask : wait_ack
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'h1;
      wait_ack();
      avs_write <= 1'h0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      avs_address <= a;
      avs_read <= 1'h1;
      wait_ack();
      avs_read <= 1'h0;
      @(posedge clock);
   endtask : rd
   task automatic pulse(input int k);
      {counter_ovf_evt, postscale_ovf_evt, sync_collision_evt, sync_done_evt} <= 4'h1 << k;
      @(posedge clock);
      {counter_ovf_evt, postscale_ovf_evt, sync_collision_evt, sync_done_evt} <= 4'h0;
      @(posedge clock);
   endtask : pulse
   always @(posedge clock) begin
      if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
         if (exp_q.size() == 0) check("queue", 32'h1, 32'h0);
         else check("readdata", avs_readdata & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   initial begin
      v = $urandom(32'hB850FE0F);
      repeat (5) @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      for (int a = 0; a < 6; a++) rd(5'(a * 4), 32'h0, 32'hFFFFFFFF);
      // Level flags follow the buffer inputs; the shifter-empty bit stays separate.
      // The bench never writes transmit data, so it cannot write while no buffer room is free.
      repeat (8) begin
         v = $urandom;
         rx_buf_not_empty <= v[0];
         tx_buf_not_full <= v[1];
         tx_shifter_empty <= v[2];
         repeat (2) @(posedge clock);
         rd(5'h00, {26'h0, v[0], v[1], 4'h0}, 32'hFFFFFFFF);
         rd(5'h10, {31'h0, v[2]}, 32'h1);
      end
      for (int k = 0; k < 4; k++) begin
         pulse(k);
         rd({2'h0, k > 1, 2'h0}, 32'h1 << (k == 1 || k == 2), 32'h3);
         rd(5'h08, 32'h1 << (k ^ (k >> 1)), 32'hF);
         wr(5'h08, 32'hF);
         wr({2'h0, k > 1, 2'h0}, 32'hFC);
         rd({2'h0, k > 1, 2'h0}, 32'h0, 32'hFFFFFFCF);
      end
      for (int m = 1; m >= 0; m--) begin
         postscale_is_1to1 <= m[0];
         period_match_evt <= 1'h1;
         @(posedge clock);
         period_match_evt <= 1'h0;
         @(posedge clock);
         rd(5'h04, {30'h0, m[0], 1'h0}, 32'h3);
         wr(5'h04, 32'h0);
      end
      // Raise the event in the very cycle the clearing write lands.
      avs_address <= 5'h00;
      avs_writedata <= 32'h0;
      avs_write <= 1'h1;
      @(posedge clock);
      sync_done_evt <= 1'h1;
      wait_ack();
      avs_write <= 1'h0;
      sync_done_evt <= 1'h0;
      @(posedge clock);
      rd(5'h00, 32'h1, 32'h3);
      wr(5'h08, 32'h3F);
      wr(5'h0C, 32'h4);
      pulse(0);
      check("irq", {31'h0, irq}, 32'h0);
      pulse(3);
      check("irq", {31'h0, irq}, 32'h1);
      wr(5'h08, 32'h4);
      check("irq", {31'h0, irq}, 32'h0);
      // A reset in mid-run must clear latched flags and the interrupt.
      pulse(1);
      pulse(3);
      rst_n <= 1'h0;
      @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      check("irq", {31'h0, irq}, 32'h0);
      rd(5'h00, 32'h0, 32'h3);
      rd(5'h04, 32'h0, 32'h3);
      end_sim();
   end
endmodule : pirf_tb_top
